// ### rtl/ugc_cfg.svh
`ifndef UGC_CFG_SVH
`define UGC_CFG_SVH
// How it works
// - Priority level from high and low bits
// - Transmit-done flag set when IN accepted
// - Bank flags set per receiving bank
// - Setup flag set on accepted SETUP
// - Stall-sent flag set; SETUP clears it
// - Frame-start flag set on SOF
// - Wake flag set on resume while suspended
// - Suspend flag set on bus suspend
// - Enable bit gates controller, transceiver, clocks
// - Suspend-clock bit stops clock, resume stays
// - Wake-up sent only when enabled, suspended 5ms
// - Resume status set on request, cleared after
// - Configured bit cleared on bus or hardware reset
// - Address enable cleared; address 0 when clear
// - Bit 4 reads zero, never written
// - Global flags gated by their enables

// ****************************************
// Register offsets
// ****************************************
`define UGC_ADDR_CON      8'hbc
`define UGC_ADDR_INT      8'hbd
`define UGC_ADDR_IEN      8'hbe
`define UGC_ADDR_EPSTA    8'hce
`define UGC_ADDR_EPIEN    8'hc2
`define UGC_ADDR_PRIO     8'hb7

// ****************************************
// Control register fields
// ****************************************
`define UGC_CON_EN        7
`define UGC_CON_SUSPEND_CLOCK_GATE_BIT   6
`define UGC_CON_SENDWU    5
`define UGC_CON_RSV       4
`define UGC_CON_UPRES     3
`define UGC_CON_RWUEN     2
`define UGC_CON_CFG       1
`define UGC_CON_ADDREN    0

// ****************************************
// Global flag fields (also enables)
// ****************************************
`define UGC_INT_WAKE      5
`define UGC_INT_EOR       4
`define UGC_INT_SOF       3
`define UGC_INT_SUSP      0
`define UGC_INT_MASK      8'h39

// ****************************************
// Endpoint flag fields
// ****************************************
`define UGC_EP_TXDONE     0
`define UGC_EP_RXB0       1
`define UGC_EP_SETUP      2
`define UGC_EP_STALL      3
`define UGC_EP_RXB1       6
`define UGC_EP_MASK       8'h4f

// ****************************************
// Reset values and timing
// ****************************************
`define UGC_RST_BYTE      8'h00
`define UGC_CLK_MHZ       100
`define UGC_SUSP_MIN_US   5000
`define UGC_SUSP_CYC      (`UGC_SUSP_MIN_US * `UGC_CLK_MHZ)
`define UGC_RESUME_US     10
`define UGC_RESUME_CYC    (`UGC_RESUME_US * `UGC_CLK_MHZ)
`endif

// ### rtl/ugc_pkg.sv
// ****************************************
// Shared types
// ****************************************
package ugc_pkg;
   typedef logic [7:0] ugc_byte_t;            // Register byte
   typedef enum logic [1:0] {
      UGC_WU_IDLE,
      UGC_WU_SEND,
      UGC_WU_HOLD
   } ugc_wu_e;                                // Remote wake-up sequencer
endpackage

// ### rtl/ugc_flags.sv
`include "ugc_cfg.svh"
// ****************************************
// Sticky flag byte: hardware set wins
// ****************************************
module ugc_flags (
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       resetn_in,
   input  wire logic       clr_in,
   // Firmware write
   input  wire logic       wr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic [7:0] mask_in,
   // Hardware sets and clears
   input  wire logic [7:0] set_in,
   input  wire logic [7:0] hwclr_in,
   // Flag state
   output logic      [7:0] flags_out
);
   typedef struct packed {
      logic [7:0] flags;                      // Flag bits
   } ugc_fl_s;

   ugc_fl_s st_ff;                            // Registered state
   ugc_fl_s nxt_st;                           // Next state

   // Next-state logic
   always_comb begin
      nxt_st = st_ff;
      if (wr_in) begin
         nxt_st.flags = st_ff.flags & wdata_in;
      end
      nxt_st.flags = nxt_st.flags & ~hwclr_in;
      nxt_st.flags = (nxt_st.flags | set_in) & mask_in;
      if (clr_in) begin
         nxt_st.flags = `UGC_RST_BYTE;
      end
   end

   // State register
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         st_ff <= '{flags: `UGC_RST_BYTE};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign flags_out = st_ff.flags;
endmodule

// ### rtl/ugc_wakeup.sv
`include "ugc_cfg.svh"
// ****************************************
// Suspend timer and upstream resume
// ****************************************
module ugc_wakeup (
   // Clock and reset
   input  wire logic mclk_in,
   input  wire logic resetn_in,
   input  wire logic clr_in,
   // Conditions
   input  wire logic bus_suspended_in,
   input  wire logic send_req_in,
   input  wire logic rwu_en_in,
   input  wire logic clocks_on_in,
   // Outputs
   output logic      resume_active_out,
   output logic      resume_drive_out
);
   typedef struct packed {
      ugc_pkg::ugc_wu_e state;                // Sequencer state
      logic [19:0]      susp_cnt;             // Suspend duration
      logic [9:0]       res_cnt;              // Resume duration
      logic             req_d;                // Request edge memory
   } ugc_wu_s;

   ugc_wu_s st_ff;                            // Registered state
   ugc_wu_s nxt_st;                           // Next state
   logic    long_susp;                        // Suspended long enough

   assign long_susp = (st_ff.susp_cnt == 20'(`UGC_SUSP_CYC));

   // Next-state logic
   always_comb begin
      nxt_st = st_ff;
      nxt_st.req_d = send_req_in;
      // Suspend duration counter, saturating
      if (!bus_suspended_in) begin
         nxt_st.susp_cnt = '0;
      end else if (!long_susp) begin
         nxt_st.susp_cnt = st_ff.susp_cnt + 20'h1;
      end
      unique case (st_ff.state)
         ugc_pkg::UGC_WU_IDLE: begin
            if (send_req_in && !st_ff.req_d && rwu_en_in) begin
               nxt_st.state = ugc_pkg::UGC_WU_HOLD;
            end
         end
         ugc_pkg::UGC_WU_HOLD: begin
            if (clocks_on_in && long_susp && rwu_en_in) begin
               nxt_st.state   = ugc_pkg::UGC_WU_SEND;
               nxt_st.res_cnt = '0;
            end
         end
         ugc_pkg::UGC_WU_SEND: begin
            if (st_ff.res_cnt == 10'(`UGC_RESUME_CYC - 1)) begin
               nxt_st.state = ugc_pkg::UGC_WU_IDLE;
            end else begin
               nxt_st.res_cnt = st_ff.res_cnt + 10'h1;
            end
         end
      endcase
      if (clr_in) begin
         nxt_st.state = ugc_pkg::UGC_WU_IDLE;
      end
   end

   // State register
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         st_ff <= '{state: ugc_pkg::UGC_WU_IDLE, susp_cnt: '0, res_cnt: '0, req_d: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign resume_active_out = (st_ff.state != ugc_pkg::UGC_WU_IDLE);
   assign resume_drive_out  = (st_ff.state == ugc_pkg::UGC_WU_SEND);
endmodule

// ### rtl/ugc_top.sv
`include "ugc_cfg.svh"
// ****************************************
// Global USB control and interrupt logic
// ****************************************
module ugc_top (
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       resetn_in,
   // Special-function register port
   input  wire logic [7:0] sfr_addr_in,
   input  wire logic       sfr_wr_in,
   input  wire logic [7:0] sfr_wdata_in,
   output logic      [7:0] sfr_rdata_out,
   // Bus events from the controller
   input  wire logic       in_accepted_in,
   input  wire logic       out_bank0_in,
   input  wire logic       out_bank1_in,
   input  wire logic       pingpong_ep_in,
   input  wire logic       setup_rcvd_in,
   input  wire logic       stall_sent_in,
   input  wire logic       ep_stallable_in,
   input  wire logic       sof_rcvd_in,
   input  wire logic       bus_reset_in,
   input  wire logic       bus_reset_end_in,
   input  wire logic       bus_suspend_in,
   input  wire logic       bus_resume_in,
   input  wire logic       bus_suspended_in,
   input  wire logic       pll_clock_on_in,
   // Controller control
   output logic            ctrl_enable_out,
   output logic            ctrl_reset_out,
   output logic            xcvr_enable_out,
   output logic            ctrl_clk_gate_out,
   output logic            resume_detect_en_out,
   output logic            upstream_resume_out,
   output logic            configured_out,
   output logic            use_default_addr_out,
   // Interrupt to core
   output logic            usb_irq_out,
   output logic [1:0]      usb_irq_level_out
);
   typedef struct packed {
      ugc_pkg::ugc_byte_t con;                // Global control
      ugc_pkg::ugc_byte_t ien;                // Global enables
      ugc_pkg::ugc_byte_t epien;              // Endpoint enables
      logic [1:0]         prio;               // Priority bits
      logic               susp_state;         // In suspend
   } ugc_top_s;

   ugc_top_s           st_ff;                 // Registered state
   ugc_top_s           nxt_st;                // Next state
   logic [7:0]         int_flags;             // Global flags
   logic [7:0]         ep_flags;              // Endpoint flags
   logic [7:0]         int_set;               // Global sets
   logic [7:0]         ep_set;                // Endpoint sets
   logic [7:0]         ep_hwclr;              // Endpoint hardware clears
   logic               ctl_clr;               // Controller reset
   logic               res_active;            // Resume status
   logic               res_drive;             // Resume signalling
   logic               clocks_on;             // All USB clocks run

   // Register write decode
   function automatic logic wr_hit(input logic [7:0] a);
      return sfr_wr_in && (sfr_addr_in == a);
   endfunction

   assign ctl_clr   = !st_ff.con[`UGC_CON_EN];
   assign clocks_on = pll_clock_on_in && !st_ff.con[`UGC_CON_SUSPEND_CLOCK_GATE_BIT];

   // ****************************************
   // Event collection
   // ****************************************
   always_comb begin
      int_set  = '0;
      ep_set   = '0;
      ep_hwclr = '0;
      ep_set[`UGC_EP_TXDONE] = in_accepted_in;
      ep_set[`UGC_EP_RXB0]   = out_bank0_in;
      ep_set[`UGC_EP_RXB1]   = out_bank1_in && pingpong_ep_in;
      ep_set[`UGC_EP_SETUP]  = setup_rcvd_in;
      ep_set[`UGC_EP_STALL]  = stall_sent_in && ep_stallable_in && !setup_rcvd_in;
      ep_hwclr[`UGC_EP_STALL] = setup_rcvd_in;
      int_set[`UGC_INT_SOF]  = sof_rcvd_in;
      int_set[`UGC_INT_EOR]  = bus_reset_end_in;
      int_set[`UGC_INT_WAKE] = bus_resume_in && st_ff.susp_state;
      int_set[`UGC_INT_SUSP] = bus_suspend_in;
   end

   // Global flag register
   ugc_flags u_int_flags (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .clr_in    (ctl_clr),
      .wr_in     (wr_hit(`UGC_ADDR_INT)),
      .wdata_in  (sfr_wdata_in),
      .mask_in   (`UGC_INT_MASK),
      .set_in    (int_set),
      .hwclr_in  (8'h00),
      .flags_out (int_flags)
   );

   // Endpoint flag register
   ugc_flags u_ep_flags (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .clr_in    (ctl_clr || bus_reset_in),
      .wr_in     (wr_hit(`UGC_ADDR_EPSTA)),
      .wdata_in  (sfr_wdata_in),
      .mask_in   (`UGC_EP_MASK),
      .set_in    (ep_set),
      .hwclr_in  (ep_hwclr),
      .flags_out (ep_flags)
   );

   // Remote wake-up sequencer
   ugc_wakeup u_wakeup (
      .mclk_in           (mclk_in),
      .resetn_in         (resetn_in),
      .clr_in            (ctl_clr),
      .bus_suspended_in  (bus_suspended_in),
      .send_req_in       (st_ff.con[`UGC_CON_SENDWU]),
      .rwu_en_in         (st_ff.con[`UGC_CON_RWUEN]),
      .clocks_on_in      (clocks_on),
      .resume_active_out (res_active),
      .resume_drive_out  (res_drive)
   );

   // ****************************************
   // Register next state
   // ****************************************
   always_comb begin
      nxt_st = st_ff;
      if (wr_hit(`UGC_ADDR_CON)) begin
         // reserved bit and status never stored
         nxt_st.con = sfr_wdata_in & 8'hef & ~(8'h01 << `UGC_CON_UPRES);
      end
      if (wr_hit(`UGC_ADDR_IEN)) begin
         nxt_st.ien = sfr_wdata_in & `UGC_INT_MASK;
      end
      if (wr_hit(`UGC_ADDR_EPIEN)) begin
         nxt_st.epien = sfr_wdata_in & `UGC_EP_MASK;
      end
      if (wr_hit(`UGC_ADDR_PRIO)) begin
         nxt_st.prio = sfr_wdata_in[1:0];
      end
      // Suspend state tracking
      if (bus_suspend_in) begin
         nxt_st.susp_state = 1'b1;
      end else if (bus_resume_in || ctl_clr) begin
         nxt_st.susp_state = 1'b0;
      end
      // address enable cleared on bus reset
      if (bus_reset_in) begin
         nxt_st.con[`UGC_CON_CFG]    = 1'b0;
         nxt_st.con[`UGC_CON_ADDREN] = 1'b0;
      end
   end

   // State register, hardware reset clears configuration
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         st_ff <= '{con: `UGC_RST_BYTE, ien: `UGC_RST_BYTE, epien: `UGC_RST_BYTE,
                    prio: 2'b00, susp_state: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // Read data, registered
   // ****************************************
   logic [7:0] rd_mux;                        // Read mux
   logic [7:0] rdata_ff;                      // Read data register

   always_comb begin
      unique case (sfr_addr_in)
         `UGC_ADDR_CON:   rd_mux = st_ff.con | ({7'h00, res_active} << `UGC_CON_UPRES);
         `UGC_ADDR_INT:   rd_mux = int_flags;
         `UGC_ADDR_IEN:   rd_mux = st_ff.ien;
         `UGC_ADDR_EPSTA: rd_mux = ep_flags;
         `UGC_ADDR_EPIEN: rd_mux = st_ff.epien;
         `UGC_ADDR_PRIO:  rd_mux = {6'h00, st_ff.prio};
         default:         rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= rd_mux;
      end
   end

   assign sfr_rdata_out = rdata_ff;

   // ****************************************
   // Outputs
   // ****************************************
   // enable, transceiver and clocks
   assign ctrl_enable_out      = st_ff.con[`UGC_CON_EN];
   assign ctrl_reset_out       = ctl_clr;
   assign xcvr_enable_out      = st_ff.con[`UGC_CON_EN];
   assign ctrl_clk_gate_out    = st_ff.con[`UGC_CON_EN] && !st_ff.con[`UGC_CON_SUSPEND_CLOCK_GATE_BIT];
   assign resume_detect_en_out = st_ff.con[`UGC_CON_EN];
   assign upstream_resume_out  = res_drive;
   assign configured_out       = st_ff.con[`UGC_CON_CFG];
   assign use_default_addr_out = !st_ff.con[`UGC_CON_ADDREN];
   assign usb_irq_out = |(int_flags & st_ff.ien) || |(ep_flags & st_ff.epien);
   assign usb_irq_level_out = st_ff.prio;
endmodule

// ### testbench/ugc_assertions.sv
`include "ugc_cfg.svh"
// *****
// Port-level checks of the control block
// *****
module ugc_assertions (
   // Clock and reset
   input wire logic       mclk_in,
   input wire logic       resetn_in,
   // Register port
   input wire logic [7:0] sfr_addr_in,
   input wire logic       sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   // Events
   input wire logic       sof_rcvd_in,
   input wire logic       bus_reset_in,
   // Outputs
   input wire logic       ctrl_enable_out,
   input wire logic       ctrl_reset_out,
   input wire logic       xcvr_enable_out,
   input wire logic       configured_out,
   input wire logic       use_default_addr_out,
   input wire logic       usb_irq_out,
   input wire logic [1:0] usb_irq_level_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] wd_ff;  // Last write data
   logic       cwr_ff; // Control write taken
   logic       pwr_ff; // Priority write taken
   logic [7:0] ien_ff; // Shadow of global enables
   // Track writes one cycle back
   always_ff @(posedge mclk_in) begin
      wd_ff <= sfr_wdata_in;
      cwr_ff <= sfr_wr_in && sfr_addr_in == `UGC_ADDR_CON && !bus_reset_in;
      pwr_ff <= sfr_wr_in && sfr_addr_in == `UGC_ADDR_PRIO;
      if (!resetn_in) begin
         ien_ff <= 8'h00;
      end else if (sfr_wr_in && sfr_addr_in == `UGC_ADDR_IEN) begin
         ien_ff <= sfr_wdata_in;
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   a_reset_inverse: assert property (ctrl_reset_out == !ctrl_enable_out)
      else $error("controller reset not inverse of enable");
   a_xcvr_needs_en: assert property (xcvr_enable_out |-> ctrl_enable_out)
      else $error("transceiver on while disabled");
   a_en_write: assert property (cwr_ff |-> ctrl_enable_out == wd_ff[7])
      else $error("enable bit not taken from write");
   a_addr_en_write: assert property (cwr_ff && wd_ff[7] |-> use_default_addr_out == !wd_ff[0])
      else $error("default address select wrong after write");
   a_level_map: assert property (pwr_ff |-> usb_irq_level_out == wd_ff[1:0])
      else $error("priority level wrong");
   a_bus_reset_clr: assert property (bus_reset_in |=> !configured_out && use_default_addr_out)
      else $error("bus reset did not clear configuration");
   a_rsv_reads_zero: assert property ($past(sfr_addr_in) == `UGC_ADDR_CON |-> !sfr_rdata_out[4])
      else $error("reserved control bit read as one");
   a_idle_quiet: assert property (!ctrl_enable_out [*2] |-> !usb_irq_out)
      else $error("interrupt while disabled");
   a_sof_irq: assert property (sof_rcvd_in && ctrl_enable_out && ien_ff[3] |=> usb_irq_out)
      else $error("frame start did not raise interrupt");
   // Main scenarios
   cover property (sof_rcvd_in && ien_ff[3]);
   cover property (bus_reset_in && configured_out);
   cover property (usb_irq_level_out == 2'h3);
endmodule
bind ugc_top ugc_assertions chk (.mclk_in, .resetn_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in,
   .sfr_rdata_out, .sof_rcvd_in, .bus_reset_in, .ctrl_enable_out, .ctrl_reset_out,
   .xcvr_enable_out, .configured_out, .use_default_addr_out, .usb_irq_out, .usb_irq_level_out);

// ### testbench/ugc_host_model.sv
// *****
// Host side: bus events as one-cycle pulses
// *****
module ugc_host_model (
   // Clock
   input  wire logic       mclk_in,
   // Event request
   input  wire logic       go_in,
   input  wire logic [3:0] ev_in,
   // Event pulses to the controller
   output logic      [9:0] pulse_out
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge mclk_in) begin
      pulse_out <= go_in ? (10'h001 << ev_in) : 10'h000;
   end
endmodule

// ### testbench/ugc_top_bench.sv
`include "ugc_cfg.svh"
module ugc_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_in, resetn_in, sfr_wr_in, go;
   logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, d, g;
   logic pingpong_ep_in, ep_stallable_in, bus_suspended_in, pll_clock_on_in;
   logic ctrl_enable_out, ctrl_reset_out, xcvr_enable_out, ctrl_clk_gate_out;
   logic resume_detect_en_out, upstream_resume_out, configured_out;
   logic use_default_addr_out, usb_irq_out;
   logic [1:0] usb_irq_level_out;
   logic [3:0] ev_code;
   logic [9:0] pulse;
   int fails, compares, seed;
   logic [3:0] gev [4] = '{4'h5, 4'h7, 4'h8, 4'h9}; // Global events
   logic [7:0] gbit [4] = '{8'h08, 8'h10, 8'h01, 8'h20};
   logic [3:0] eev [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4}; // Endpoint events
   logic [7:0] ebit [5] = '{8'h01, 8'h02, 8'h40, 8'h04, 8'h08};
   ugc_host_model host (.mclk_in, .go_in(go), .ev_in(ev_code), .pulse_out(pulse));
   ugc_top uut (.mclk_in, .resetn_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out,
      .in_accepted_in(pulse[0]), .out_bank0_in(pulse[1]), .out_bank1_in(pulse[2]),
      .setup_rcvd_in(pulse[3]), .stall_sent_in(pulse[4]), .sof_rcvd_in(pulse[5]),
      .bus_reset_in(pulse[6]), .bus_reset_end_in(pulse[7]), .bus_suspend_in(pulse[8]),
      .bus_resume_in(pulse[9]), .pingpong_ep_in, .ep_stallable_in, .bus_suspended_in,
      .pll_clock_on_in, .ctrl_enable_out, .ctrl_reset_out, .xcvr_enable_out,
      .ctrl_clk_gate_out, .resume_detect_en_out, .upstream_resume_out, .configured_out,
      .use_default_addr_out, .usb_irq_out, .usb_irq_level_out);
   // Clock source
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // Expected control readback: bits 4 and 3 not stored
   function automatic logic [7:0] exp_con(input logic [7:0] w);
      return w & 8'he7;
   endfunction
   // Expected enable readback
   function automatic logic [7:0] exp_ien(input logic [7:0] w);
      return w & `UGC_INT_MASK;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk_in);
      #1;
      sfr_addr_in = a;
      sfr_wdata_in = v;
      sfr_wr_in = 1'b1;
      @(posedge mclk_in);
      #1;
      sfr_wr_in = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk_in);
      #1;
      sfr_addr_in = a;
      @(posedge mclk_in);
      #1;
      v = sfr_rdata_out;
   endtask
   // Request one host event; returns once the flag has landed
   task automatic ev(input logic [3:0] c);
      @(posedge mclk_in);
      #1;
      ev_code = c;
      go = 1'b1;
      @(posedge mclk_in);
      #1;
      go = 1'b0;
      @(posedge mclk_in);
      #1;
   endtask
   task automatic end_sim;
      if (fails == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      fails++;
      end_sim();
   end
   // Main sequence
   initial begin
      {fails, compares, seed} = {32'd0, 32'd0, 32'hc3f3};
      {resetn_in, sfr_wr_in, go, sfr_addr_in, sfr_wdata_in, ev_code} = '0;
      {pingpong_ep_in, ep_stallable_in, bus_suspended_in, pll_clock_on_in} = 4'hd;
      repeat (5) @(posedge mclk_in);
      #1;
      resetn_in = 1'b1;
      rd(`UGC_ADDR_CON, d);
      chk(d, `UGC_RST_BYTE);
      chk(8'({ctrl_reset_out, use_default_addr_out, usb_irq_out}), 8'h06);
      // firmware sets configured and address enable
      wr(`UGC_ADDR_CON, 8'h9f);
      rd(`UGC_ADDR_CON, d);
      chk(d, exp_con(8'h9f));
      chk(8'({configured_out, use_default_addr_out, xcvr_enable_out}), 8'h05);
      ev(4'h6);
      rd(`UGC_ADDR_CON, d);
      chk(d, 8'h84);
      chk(8'({configured_out, use_default_addr_out}), 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(`UGC_ADDR_PRIO, 8'(i));
         chk(8'(usb_irq_level_out), 8'(i));
      end
      // Random global enables against frame start
      repeat (6) begin
         d = 8'($random(seed));
         wr(`UGC_ADDR_IEN, d);
         rd(`UGC_ADDR_IEN, g);
         chk(g, exp_ien(d));
         ev(4'h5);
         chk(8'(usb_irq_out), 8'(d[3]));
         rd(`UGC_ADDR_INT, g);
         chk(g, 8'h08);
         wr(`UGC_ADDR_INT, 8'h00);
         chk(8'(usb_irq_out), 8'h00);
      end
      wr(`UGC_ADDR_IEN, `UGC_INT_MASK);
      bus_suspended_in = 1'b1;
      foreach (gev[k]) begin
         ev(gev[k]);
         rd(`UGC_ADDR_INT, g);
         chk(g, gbit[k]);
         chk(8'(usb_irq_out), 8'h01);
         wr(`UGC_ADDR_INT, 8'h00);
      end
      bus_suspended_in = 1'b0;
      // Hardware set lands on the clearing write
      wr(`UGC_ADDR_IEN, 8'h08);
      @(posedge mclk_in);
      #1;
      {ev_code, go} = {4'h5, 1'b1};
      @(posedge mclk_in);
      #1;
      {go, sfr_addr_in, sfr_wdata_in, sfr_wr_in} = {1'b0, 8'(`UGC_ADDR_INT), 8'h00, 1'b1};
      @(posedge mclk_in);
      #1;
      sfr_wr_in = 1'b0;
      chk(8'(usb_irq_out), 8'h01);
      wr(`UGC_ADDR_INT, 8'h00);
      wr(`UGC_ADDR_EPIEN, `UGC_EP_MASK);
      foreach (eev[k]) begin
         ev(eev[k]);
         rd(`UGC_ADDR_EPSTA, g);
         chk(g, ebit[k]);
         chk(8'(usb_irq_out), 8'h01);
         wr(`UGC_ADDR_EPSTA, 8'h00);
      end
      ev(4'h4);
      ev(4'h3);
      rd(`UGC_ADDR_EPSTA, g);
      chk(g, 8'h04);
      wr(`UGC_ADDR_EPSTA, 8'h00);
      // Plain endpoint without stall: bank 1 and stall never set
      {pingpong_ep_in, ep_stallable_in} = 2'b00;
      ev(4'h2);
      ev(4'h4);
      rd(`UGC_ADDR_EPSTA, g);
      chk(g, 8'h00);
      {pingpong_ep_in, ep_stallable_in} = 2'b11;
      chk(8'(ctrl_clk_gate_out), 8'h01);
      wr(`UGC_ADDR_CON, 8'hc4);
      chk(8'({ctrl_clk_gate_out, resume_detect_en_out}), 8'h01);
      wr(`UGC_ADDR_CON, 8'h84);
      ev(4'h5);
      wr(`UGC_ADDR_CON, 8'h00);
      @(posedge mclk_in);
      #1;
      chk(8'({usb_irq_out, ctrl_reset_out, xcvr_enable_out}), 8'h02);
      // remote wake request without and with enable
      wr(`UGC_ADDR_CON, 8'h80);
      wr(`UGC_ADDR_CON, 8'ha0);
      rd(`UGC_ADDR_CON, d);
      chk(d, 8'ha0);
      wr(`UGC_ADDR_CON, 8'h84);
      wr(`UGC_ADDR_CON, 8'ha4);
      rd(`UGC_ADDR_CON, d);
      chk(d, 8'hac);
      chk(8'(upstream_resume_out), 8'h00);
      end_sim();
   end
endmodule
